/* File: arcg_pkg.sv */
// Shared constants and types for the converter and real-time clock generators
package arcg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_USB_SEL   = 8'h5C; // USB source indication
	localparam logic [7:0] OFS_CONV_CTRL = 8'h60; // Converter control
	localparam logic [7:0] OFS_CONV_DIV  = 8'h64; // Converter divisor
	localparam logic [7:0] OFS_CONV_SEL  = 8'h68; // Converter source indication
	localparam logic [7:0] OFS_RTC_CTRL  = 8'h6C; // RTC control
	localparam logic [7:0] OFS_RTC_DIV   = 8'h70; // RTC divisor
	localparam logic [7:0] OFS_RTC_SEL   = 8'h74; // RTC source indication
	localparam logic [7:0] OFS_STATUS    = 8'hA0; // Generator status

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned AUX_LSB  = 5;  // Auxiliary source select 7:5
	localparam int unsigned KILL_BIT = 10; // Hard stop
	localparam int unsigned EN_BIT   = 11; // Clean enable
	localparam int unsigned DLY_LSB  = 16; // Enable delay 17:16
	localparam int unsigned STEP_BIT = 20; // Phase step
	localparam int unsigned INT_LSB  = 8;  // Integer divisor low bit

	////////////////////////////////////////////////////////////////////////////
	// Reset values and writable masks
	localparam logic [31:0] SEL_RESET  = 32'h00000001; // Hardwired indication
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [31:0] DIV_RESET  = 32'h00000100; // Integer one
	localparam logic [31:0] CTRL_MASK  = 32'h00130CE0;
	localparam logic [31:0] CONV_MASK  = 32'h00000300; // Integer 9:8 only
	localparam logic [31:0] RTC_MASK   = 32'hFFFFFFFF; // Integer and fraction

	////////////////////////////////////////////////////////////////////////////
	// Widths and source codes
	localparam int unsigned NUM_SRC    = 6;  // Auxiliary inputs
	localparam int unsigned CONV_INT_W = 2;  // Converter integer width
	localparam int unsigned RTC_INT_W  = 24; // RTC integer width
	localparam int unsigned DIVISOR_FRACTION_W     = 8;  // Fraction width
	// Period counter must hold the full 24-bit RTC integer plus a fraction carry
	localparam int unsigned PER_W      = 25; // Period counter, up to 2^24
	localparam logic [PER_W-1:0] PER_ZERO_INT = 25'h0010000; // Integer zero
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	// Generator run state, one-hot
	typedef enum logic [1:0] {
		ARCG_STOP = 2'b01,
		ARCG_RUN  = 2'b10
	} arcg_state_t;

endpackage : arcg_pkg

/* File: arcg_slice_if.sv */
// Control and status bundle between the register block and one generator
`timescale 1ns/1ns
`default_nettype none
interface arcg_slice_if;
	logic [2:0]  aux_sel;  // Auxiliary source code
	logic        enable;   // Clean enable
	logic        kill;     // Hard stop, taken from the next register value
	logic [1:0]  delay;    // Enable delay in input cycles
	logic        step;     // Phase step level
	logic [23:0] div_int;  // Integer divisor, low bits used
	logic [7:0]  div_divisor_fraction; // Fractional divisor
	logic        clk_out;  // Generated clock
	logic        running;  // Generator state

	modport ctl (output aux_sel, enable, kill, delay, step, div_int, div_divisor_fraction,
		input clk_out, running);
	modport gen (input aux_sel, enable, kill, delay, step, div_int, div_divisor_fraction,
		output clk_out, running);
endinterface : arcg_slice_if
`default_nettype wire

/* File: arcg_sync.sv */
// Three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ns
`default_nettype none
module arcg_sync (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic async_in,
	output var  logic level,
	output var  logic rise
);
	logic s1_q, s2_q, s3_q;      // Chain, s1 seen by s2 only
	logic lvl_q, lvl_d;          // Accepted level
	logic rise_q, rise_d;        // One-cycle rise pulse

	// A change counts once stages two and three agree
	always_comb begin
		lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
		rise_d = lvl_d & ~lvl_q;
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_q   <= 1'b0;
			s2_q   <= 1'b0;
			s3_q   <= 1'b0;
			lvl_q  <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			s1_q   <= async_in;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			lvl_q  <= lvl_d;
			rise_q <= rise_d;
		end
	end

	assign level = lvl_q;
	assign rise  = rise_q;
endmodule : arcg_sync
`default_nettype wire

/* File: arcg_gen.sv */
// One clock generator slice: source pick, enable, step and divider
`timescale 1ns/1ns
`default_nettype none
module arcg_gen
	import arcg_pkg::*;
#(
	parameter int unsigned INT_W = RTC_INT_W
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic [NUM_SRC-1:0] src_level,
	input  wire logic [NUM_SRC-1:0] src_rise,
	arcg_slice_if.gen               cfg
);
	arcg_state_t        state_q, state_d; // Run state
	logic [PER_W-1:0]   cnt_q, cnt_d;     // Position within period
	logic [PER_W-1:0]   per_q, per_d;     // Current period in input cycles
	logic [DIVISOR_FRACTION_W-1:0]  acc_q, acc_d;     // Fraction accumulator
	logic [2:0]         pipe_q, pipe_d;   // Enable history per input cycle
	logic [1:0]         dly_q, dly_d;     // Latched enable delay
	logic               step_q, step_d;   // Previous step level
	logic               phase_step_q, phase_step_d; // Pending phase step
	logic               out_q, out_d;     // Output clock flop
	logic               tick, lvl, eff_en, advance;
	logic [INT_W-1:0]   int_val;
	logic [PER_W-1:0]   int_ext;
	logic [DIVISOR_FRACTION_W:0]    acc_sum;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		// Source pick glitches on change; codes above five give nothing
		tick    = (cfg.aux_sel < 3'(NUM_SRC)) ? src_rise[cfg.aux_sel]  : 1'b0;
		lvl     = (cfg.aux_sel < 3'(NUM_SRC)) ? src_level[cfg.aux_sel] : 1'b0;
		int_val = cfg.div_int[INT_W-1:0];
		int_ext = (int_val == '0) ? PER_ZERO_INT : PER_W'(int_val);
		acc_sum = {1'b0, acc_q} + {1'b0, cfg.div_divisor_fraction};
		state_d = state_q;
		cnt_d   = cnt_q;
		per_d   = per_q;
		acc_d   = acc_q;
		pipe_d  = pipe_q;
		dly_d   = dly_q;
		out_d   = 1'b0;
		step_d  = cfg.step;
		// Delay only taken while disabled, later writes ignored
		if (!cfg.enable) begin
			dly_d = cfg.delay;
		end
		if (tick) begin
			pipe_d = {pipe_q[1:0], cfg.enable};
		end
		// Enable held off by zero to three input cycles
		eff_en  = (dly_q == 2'h0) ? cfg.enable : pipe_q[dly_q - 2'h1];
		// A step edge swallows one input cycle; a new edge wins over use
		advance = tick & ~phase_step_q;
		phase_step_d = (cfg.step ^ step_q) | (phase_step_q & ~tick);
		unique case (state_q)
			ARCG_STOP: begin
				if (advance && eff_en) begin
					state_d = ARCG_RUN;
					cnt_d   = '0;
					per_d   = int_ext;
					acc_d   = '0;
				end
			end
			ARCG_RUN: begin
				if (advance) begin
					if (cnt_q == per_q - PER_W'(1)) begin
						// Stop only at a period boundary, output already low for divisors above one
						if (!eff_en) begin
							state_d = ARCG_STOP;
						end
						// Divisor changes land at the boundary
						cnt_d = '0;
						acc_d = acc_sum[DIVISOR_FRACTION_W-1:0];
						per_d = int_ext + PER_W'(acc_sum[DIVISOR_FRACTION_W]);
					end else begin
						cnt_d = cnt_q + PER_W'(1);
					end
				end
			end
		endcase
		if (state_d == ARCG_RUN) begin
			out_d = (per_d == PER_W'(1)) ? lvl : (cnt_d < ((per_d + PER_W'(1)) >> 1));
		end
		// Hard stop overrides everything at once
		if (cfg.kill) begin
			state_d = ARCG_STOP;
			cnt_d   = '0;
			pipe_d  = '0;
			out_d   = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ARCG_STOP;
			cnt_q   <= '0;
			per_q   <= PER_W'(1);
			acc_q   <= '0;
			pipe_q  <= '0;
			dly_q   <= '0;
			step_q  <= 1'b0;
			phase_step_q <= 1'b0;
			out_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			per_q   <= per_d;
			acc_q   <= acc_d;
			pipe_q  <= pipe_d;
			dly_q   <= dly_d;
			step_q  <= step_d;
			phase_step_q <= phase_step_d;
			out_q   <= out_d;
		end
	end

	assign cfg.clk_out = out_q;
	assign cfg.running = (state_q == ARCG_RUN);
endmodule : arcg_gen
`default_nettype wire

/* File: arcg_top.sv */
// Converter and RTC clock generators with their AHB-Lite register block
//
// Contract
// - Control bits 7:5 pick one of six sources
// - Source change may glitch; change while stopped
// - Other fields except delay take effect while running; delay is taken only while enable is off
// - Enable bit 11 starts and stops cleanly
// - Hard stop bit 10 halts output at once
// - Bits 17:16 delay enable up to three cycles
// - Step bit 20 edge shifts phase one cycle
// - Converter integer divisor bits 9:8, reset one
// - RTC integer bits 31:8, zero means 65536
// - RTC fraction bits 7:0 added to divisor
// - Source indication registers read constant one
`timescale 1ns/1ns
`default_nettype none
module arcg_top
	import arcg_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RSTN,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output var  logic [31:0] HRDATA,
	output var  logic        HREADYOUT,
	output var  logic        HRESP,
	// Auxiliary clock sources
	input  wire logic        USB_PLL_OUTPUT,
	input  wire logic        SYSTEM_PLL_OUTPUT,
	input  wire logic        RING_OSC_PHASE_OUTPUT,
	input  wire logic        CRYSTAL_OSC_OUTPUT,
	input  wire logic        GENERAL_CLOCK_INPUT_A,
	input  wire logic        GENERAL_CLOCK_INPUT_B,
	// Generated clocks
	output var  logic        CONVERTER_CLK,
	output var  logic        RTC_CLK
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Source pins in code order
	logic [NUM_SRC-1:0] src_pin;
	// Synchronised levels and rise pulses
	logic [NUM_SRC-1:0] src_level;
	logic [NUM_SRC-1:0] src_rise;

	// Software registers
	logic [31:0] conv_ctrl_q, conv_ctrl_d;
	logic [31:0] conv_div_q,  conv_div_d;
	logic [31:0] rtc_ctrl_q,  rtc_ctrl_d;
	logic [31:0] rtc_div_q,   rtc_div_d;

	// Data phase bookkeeping
	logic        wr_pend_q, wr_pend_d;
	logic [7:0]  wr_addr_q, wr_addr_d;
	logic [31:0] rdata_q,   rdata_d;
	logic        ready_q;
	logic        resp_q;

	// Address phase decode
	logic        take;
	logic [31:0] status_word;

	// Output clocks, taken straight from the slice flops
	logic        conv_clk_q;
	logic        rtc_clk_q;

	// Bundles to the two slices
	arcg_slice_if conv_if ();
	arcg_slice_if rtc_if ();

	////////////////////////////////////////////////////////////////////////////
	// Source synchronisers

	// Order matches the source code enumeration
	assign src_pin = {
		GENERAL_CLOCK_INPUT_B,
		GENERAL_CLOCK_INPUT_A,
		CRYSTAL_OSC_OUTPUT,
		RING_OSC_PHASE_OUTPUT,
		SYSTEM_PLL_OUTPUT,
		USB_PLL_OUTPUT
	};

	// Sources arrive from foreign domains, so each is synchronised.
	// Limitation: a source must run well below half of CLK_SYS to be seen.
	generate
		for (genvar gi = 0; gi < NUM_SRC; gi++) begin : g_src
			arcg_sync u_sync (
				.clk      (CLK_SYS),
				.rstn     (RSTN),
				.async_in (src_pin[gi]),
				.level    (src_level[gi]),
				.rise     (src_rise[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite address phase

	// Transfer taken on a selected, ready, NONSEQ or SEQ cycle
	assign take = HSEL & HREADY & HTRANS[1];

	// Status word shows both generators
	assign status_word = {
		28'h0000000,
		rtc_if.clk_out,
		rtc_if.running,
		conv_if.clk_out,
		conv_if.running
	};

	////////////////////////////////////////////////////////////////////////////
	// Register next values and read mux

	// Write lands in the data phase; reads use next values so that
	// a read right behind a write sees the new contents.
	always_comb begin
		conv_ctrl_d = conv_ctrl_q;
		conv_div_d  = conv_div_q;
		rtc_ctrl_d  = rtc_ctrl_q;
		rtc_div_d   = rtc_div_q;
		wr_pend_d   = 1'b0;
		wr_addr_d   = wr_addr_q;
		rdata_d     = rdata_q;

		// Data phase of a write
		if (wr_pend_q) begin
			unique case (wr_addr_q)
				// Control fields change on the fly
				OFS_CONV_CTRL: begin
					conv_ctrl_d = HWDATA & CTRL_MASK;
				end
				OFS_CONV_DIV: begin
					conv_div_d = HWDATA & CONV_MASK;
				end
				OFS_RTC_CTRL: begin
					rtc_ctrl_d = HWDATA & CTRL_MASK;
				end
				OFS_RTC_DIV: begin
					rtc_div_d = HWDATA & RTC_MASK;
				end
				// Read-only and unmapped words drop the data
				default: begin
				end
			endcase
		end

		// Address phase
		if (take) begin
			if (HWRITE) begin
				wr_pend_d = 1'b1;
				wr_addr_d = HADDR[7:0];
				rdata_d   = 32'h00000000;
			end else begin
				unique case (HADDR[7:0])
					// Indication registers hardwired
					OFS_USB_SEL:   rdata_d = SEL_RESET;
					OFS_CONV_SEL:  rdata_d = SEL_RESET;
					OFS_RTC_SEL:   rdata_d = SEL_RESET;
					OFS_CONV_CTRL: rdata_d = conv_ctrl_d;
					OFS_CONV_DIV:  rdata_d = conv_div_d;
					OFS_RTC_CTRL:  rdata_d = rtc_ctrl_d;
					OFS_RTC_DIV:   rdata_d = rtc_div_d;
					OFS_STATUS:    rdata_d = status_word;
					// Unmapped words read zero
					default:       rdata_d = 32'h00000000;
				endcase
			end
		end

		// Upper address bits outside the block read as zero too
		if (take && !HWRITE && (HADDR[31:8] != 24'h000000)) begin
			rdata_d = 32'h00000000;
		end
		if (take && HWRITE && (HADDR[31:8] != 24'h000000)) begin
			wr_pend_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register flops

	// Zero-wait slave: ready and OKAY always
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			conv_ctrl_q <= CTRL_RESET;
			conv_div_q  <= DIV_RESET;
			rtc_ctrl_q  <= CTRL_RESET;
			rtc_div_q   <= DIV_RESET;
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= 8'h00;
			rdata_q     <= 32'h00000000;
			ready_q     <= 1'b1;
			resp_q      <= 1'b0;
		end else begin
			conv_ctrl_q <= conv_ctrl_d;
			conv_div_q  <= conv_div_d;
			rtc_ctrl_q  <= rtc_ctrl_d;
			rtc_div_q   <= rtc_div_d;
			wr_pend_q   <= wr_pend_d;
			wr_addr_q   <= wr_addr_d;
			rdata_q     <= rdata_d;
			ready_q     <= 1'b1;
			resp_q      <= 1'b0;
		end
	end

	assign HRDATA    = rdata_q;
	assign HREADYOUT = ready_q;
	assign HRESP     = resp_q;

	////////////////////////////////////////////////////////////////////////////
	// Converter slice controls

	// Source select
	assign conv_if.aux_sel  = conv_ctrl_q[AUX_LSB +: 3];
	// Clean enable
	assign conv_if.enable   = conv_ctrl_q[EN_BIT];
	// Kill taken from the next value to cut a cycle of latency
	assign conv_if.kill     = conv_ctrl_d[KILL_BIT];
	// Enable delay
	assign conv_if.delay    = conv_ctrl_q[DLY_LSB +: 2];
	// Phase step level
	assign conv_if.step     = conv_ctrl_q[STEP_BIT];
	// Integer only, no fraction on this slice
	assign conv_if.div_int  = {22'h00000, conv_div_q[INT_LSB +: CONV_INT_W]};
	assign conv_if.div_divisor_fraction = 8'h00;

	arcg_gen #(
		.INT_W (CONV_INT_W)
	) u_conv (
		.clk       (CLK_SYS),
		.rstn      (RSTN),
		.src_level (src_level),
		.src_rise  (src_rise),
		.cfg       (conv_if)
	);

	////////////////////////////////////////////////////////////////////////////
	// RTC slice controls

	// Source select
	assign rtc_if.aux_sel  = rtc_ctrl_q[AUX_LSB +: 3];
	// Clean enable
	assign rtc_if.enable   = rtc_ctrl_q[EN_BIT];
	// Hard stop from the next value
	assign rtc_if.kill     = rtc_ctrl_d[KILL_BIT];
	// Enable delay
	assign rtc_if.delay    = rtc_ctrl_q[DLY_LSB +: 2];
	// Phase step level
	assign rtc_if.step     = rtc_ctrl_q[STEP_BIT];
	// Integer 31:8 and fraction 7:0
	assign rtc_if.div_int  = rtc_div_q[INT_LSB +: RTC_INT_W];
	assign rtc_if.div_divisor_fraction = rtc_div_q[DIVISOR_FRACTION_W-1:0];

	arcg_gen #(
		.INT_W (RTC_INT_W)
	) u_rtc (
		.clk       (CLK_SYS),
		.rstn      (RSTN),
		.src_level (src_level),
		.src_rise  (src_rise),
		.cfg       (rtc_if)
	);

	////////////////////////////////////////////////////////////////////////////
	// Output clocks

	// Slice outputs are flops already; these pass them straight out
	assign conv_clk_q    = conv_if.clk_out;
	assign rtc_clk_q     = rtc_if.clk_out;
	assign CONVERTER_CLK = conv_clk_q;
	assign RTC_CLK       = rtc_clk_q;

endmodule : arcg_top
`default_nettype wire

/* File: arcg_top_asserts.sv */
// Port-level checker for the converter and RTC clock generators
`timescale 1ns/1ns
`default_nettype none
module arcg_top_asserts
	import arcg_pkg::*;
(
	input wire logic        CLK_SYS,
	input wire logic        RSTN,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        CONVERTER_CLK,
	input wire logic        RTC_CLK
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	////////////////////////////////////////////////////////////
	// Bus phase tracking and shadows of kill, enable and delay
	logic       take;       // Transfer accepted this edge
	logic       rd_q, wr_q; // Data phase pending
	logic [7:0] a_q;        // Address of that data phase
	logic       kc_q, kr_q; // Kill bits
	logic       ec_q, dc_q; // Converter enable, delay nonzero
	assign take = HSEL && HREADY && HTRANS[1] && HADDR[31:8] == 24'h0;

	// Delay latches on a write seen while ec_q is off, the enabling write included; the slice takes it only while its enable bit is off
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			a_q  <= 8'h00;
			kc_q <= 1'b0;
			kr_q <= 1'b0;
			ec_q <= 1'b0;
			dc_q <= 1'b0;
		end else begin
			rd_q <= take && !HWRITE;
			wr_q <= take && HWRITE;
			a_q  <= HADDR[7:0];
			if (wr_q && a_q == OFS_CONV_CTRL) begin
				kc_q <= HWDATA[10];
				ec_q <= HWDATA[11];
				if (!ec_q) begin
					dc_q <= HWDATA[17:16] != 2'h0;
				end
			end
			if (wr_q && a_q == OFS_RTC_CTRL) begin
				kr_q <= HWDATA[10];
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Properties
	property p_bus_ok;
		HREADYOUT && !HRESP;
	endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
	property p_sel_const;
		rd_q && (a_q == OFS_USB_SEL || a_q == OFS_CONV_SEL || a_q == OFS_RTC_SEL)
			|-> HRDATA == 32'h00000001;
	endproperty
	a_sel_const: assert property (p_sel_const) else $error("indication not one");
	property p_div_rsv;
		rd_q && a_q == OFS_CONV_DIV |-> (HRDATA & 32'hFFFFFCFF) == 32'h0;
	endproperty
	a_div_rsv: assert property (p_div_rsv) else $error("divisor spare bits set");
	property p_ctrl_rsv;
		rd_q && (a_q == OFS_CONV_CTRL || a_q == OFS_RTC_CTRL)
			|-> (HRDATA & 32'hFFECF31F) == 32'h0;
	endproperty
	a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control spare bits set");
	property p_kill_c;
		kc_q |-> !CONVERTER_CLK;
	endproperty
	a_kill_c: assert property (p_kill_c) else $error("converter clock high while killed");
	property p_kill_r;
		kr_q |-> !RTC_CLK;
	endproperty
	a_kill_r: assert property (p_kill_r) else $error("rtc clock high while killed");
	property p_hold_c;
		!ec_q && $past(!ec_q) && !dc_q && !CONVERTER_CLK |=> !CONVERTER_CLK;
	endproperty
	a_hold_c: assert property (p_hold_c) else $error("converter clock rose while off");
	property p_hi_c;
		$rose(CONVERTER_CLK) |=> (CONVERTER_CLK || kc_q) [*2];
	endproperty
	a_hi_c: assert property (p_hi_c) else $error("converter high pulse cut short");
	property p_lo_c;
		$fell(CONVERTER_CLK) |=> (!CONVERTER_CLK) [*2];
	endproperty
	a_lo_c: assert property (p_lo_c) else $error("converter low pulse cut short");
	property p_hi_r;
		$rose(RTC_CLK) |=> (RTC_CLK || kr_q) [*2];
	endproperty
	a_hi_r: assert property (p_hi_r) else $error("rtc high pulse cut short");

	// Main scenarios reached
	c_kill: cover property (kc_q && $fell(CONVERTER_CLK));
	c_rtc: cover property ($rose(RTC_CLK));
	c_sel: cover property (rd_q && a_q == OFS_CONV_SEL);
endmodule : arcg_top_asserts

bind arcg_top arcg_top_asserts u_asserts (.CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE,
	.HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .CONVERTER_CLK, .RTC_CLK);
`default_nettype wire

/* File: arcg_consumer_model.sv */
// Source clock makers and consumers counting generated clock edges
`timescale 1ns/1ns
`default_nettype none
module arcg_consumer_model (
	input  wire logic       conv_clk, // Converter clock in
	input  wire logic       rtc_clk,  // RTC clock in
	output wire logic [5:0] src,      // Source levels, codes 0..5
	output var  int         conv_cnt, // Converter rising edges
	output var  int         rtc_cnt   // RTC rising edges
);
	// Half period (4+k)*50+7 ns: over three system cycles, drifting phase
	for (genvar k = 0; k < 6; k++) begin : g_src
		logic s = 1'b0; // Free-running source level
		always #((4 + k) * 50 + 7) s = ~s;
		assign src[k] = s;
	end

	// Edge counters; the bench takes differences over a window
	initial conv_cnt = 0;
	initial rtc_cnt = 0;
	always @(posedge conv_clk) conv_cnt++;
	always @(posedge rtc_clk) rtc_cnt++;
endmodule : arcg_consumer_model
`default_nettype wire

/* File: adc_rtc_clock_generator_test.sv */
// Self-checking bench for the converter and RTC clock generators
`timescale 1ns/1ns
`default_nettype none
module adc_rtc_clock_generator_test;
	import arcg_pkg::*;
	logic        clk_sys = 1'b0; // 50 ns system clock
	logic        rstn;           // Active-low reset
	logic        hsel, hwrite;   // Bus select and direction
	logic [1:0]  htrans;         // Transfer kind
	logic [31:0] haddr, hwdata;  // Address and write data
	logic [31:0] hrdata;         // Read data
	logic        hreadyout, hresp;
	logic        conv_clk, rtc_clk;
	wire  [5:0]  src;            // Source levels
	int          conv_cnt, rtc_cnt;
	int          n_errors = 0;
	int          n_tests = 0;
	// Register table: place, reset value, value after all-ones write
	localparam logic [7:0] OFS_LIST [8] = '{8'h5C, 8'h60, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h40};
	localparam logic [31:0] RST_LIST [8] = '{32'h1, 32'h0, 32'h100, 32'h1, 32'h0, 32'h100,
		32'h1, 32'h0};
	localparam logic [31:0] ONE_LIST [8] = '{32'h1, 32'h00130CE0, 32'h300, 32'h1,
		32'h00130CE0, 32'hFFFFFFFF, 32'h1, 32'h0};

	always #25 clk_sys = ~clk_sys;

	arcg_top dut (.CLK_SYS(clk_sys), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .USB_PLL_OUTPUT(src[0]),
		.SYSTEM_PLL_OUTPUT(src[1]), .RING_OSC_PHASE_OUTPUT(src[2]), .CRYSTAL_OSC_OUTPUT(src[3]),
		.GENERAL_CLOCK_INPUT_A(src[4]), .GENERAL_CLOCK_INPUT_B(src[5]),
		.CONVERTER_CLK(conv_clk), .RTC_CLK(rtc_clk));
	arcg_consumer_model u_far (.conv_clk(conv_clk), .rtc_clk(rtc_clk), .src(src),
		.conv_cnt(conv_cnt), .rtc_cnt(rtc_cnt));

	////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	// Ready wait at rising edges; only the watchdog ends a stuck wait
	task automatic wait_rdy;
		do begin
			@(posedge clk_sys);
		end while (hreadyout !== 1'b1);
	endtask : wait_rdy

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(nm, x, exp);
	endtask : rd_chk

	// Rising edges over a window; one edge of slack for phase, none for silence
	task automatic measure(input string nm, input bit rtc, input int cyc, input int exp);
		int c0, d;
		c0 = rtc ? rtc_cnt : conv_cnt;
		repeat (cyc) @(posedge clk_sys);
		d = (rtc ? rtc_cnt : conv_cnt) - c0;
		if (exp > 0 && d >= exp - 1 && d <= exp + 1) d = exp;
		chk(nm, 32'(d), 32'(exp));
	endtask : measure

	// Stop, pick source and delay while stopped, set divisor, start
	task automatic gen_case(input bit rtc, input logic [2:0] s, input logic [31:0] dv,
		input int per, input int cyc);
		logic [7:0] c;
		c = rtc ? OFS_RTC_CTRL : OFS_CONV_CTRL;
		wr(c, 32'h0);
		// Let the running period end so the source swap happens while stopped
		repeat (100) @(posedge clk_sys);
		wr(c, {14'h0, s[1:0], 8'h0, s, 5'h0});
		wr(rtc ? OFS_RTC_DIV : OFS_CONV_DIV, dv);
		wr(c, {14'h0, s[1:0], 4'h0, 1'b1, 3'h0, s, 5'h0});
		repeat (100) @(posedge clk_sys);
		measure("rate", rtc, cyc, cyc * 50 / per);
	endtask : gen_case

	////////////////////////////////////////////////////////////
	// Watchdog far beyond the expected run of some 8600 cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_errors++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		rstn <= 1'b0;
		hsel <= 1'b0;
		hwrite <= 1'b0;
		htrans <= 2'h0;
		haddr <= 32'h0;
		hwdata <= 32'h0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++) rd_chk("reset", OFS_LIST[i], RST_LIST[i]);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_LIST[i], 32'hFFFFFFFF);
			rd_chk("ones", OFS_LIST[i], ONE_LIST[i]);
		end
		// Every source code, divisors one to three
		for (int k = 0; k < 6; k++) begin
			gen_case(1'b0, 3'(k), 32'((k % 3 + 1) << 8), (k % 3 + 1) * 2 * ((4 + k) * 50 + 7), 400);
		end
		gen_case(1'b1, 3'h3, 32'h300, 2142, 1000);
		gen_case(1'b1, 3'h3, 32'h380, 2499, 1000);
		gen_case(1'b0, 3'h0, 32'h200, 828, 400);
		// Eight step edges while running swallow four output periods
		fork
			measure("step", 1'b0, 400, 20000 / 828 - 4);
			for (int j = 0; j < 8; j++) begin
				repeat (40) @(posedge clk_sys);
				wr(OFS_CONV_CTRL, j[0] ? 32'h800 : 32'h00100800);
			end
		join
		wr(OFS_CONV_DIV, 32'h100);
		repeat (60) @(posedge clk_sys);
		measure("ondiv", 1'b0, 400, 48);
		wr(OFS_CONV_CTRL, 32'hC00);
		measure("kill", 1'b0, 200, 0);
		wr(OFS_CONV_CTRL, 32'h800);
		repeat (60) @(posedge clk_sys);
		measure("restart", 1'b0, 400, 48);
		wr(OFS_CONV_CTRL, 32'h0);
		repeat (60) @(posedge clk_sys);
		measure("off", 1'b0, 200, 0);
		tally_and_finish();
	end
endmodule : adc_rtc_clock_generator_test
`default_nettype wire
